// *** rtl/undervolt_consts.svh ***
// Constants for the low-voltage detect and reset controller.
`ifndef UNDERVOLT_CONSTS_SVH
`define UNDERVOLT_CONSTS_SVH
`define UV_ADDR_CTRL 4'h0
`define UV_ADDR_MASK 4'h1
`define UV_ADDR_STAT 4'h2
`define UV_BIT_FLAG 6
`define UV_BIT_STATE 5
`define UV_BIT_IE 4
`define UV_BIT_WE 3
`define UV_BIT_EN 2
`define UV_CTRL_RESET 8'h20
`define UV_CTRL_WMASK 8'h1f
`define UV_DIP_LIMIT_US 80
`define UV_CLK_MHZ 125
`define UV_DIP_CYCLES (`UV_DIP_LIMIT_US * `UV_CLK_MHZ)
`define UV_EV_DETECT 0
`define UV_EV_DIP 1
`define UV_EV_RESET 2
`endif

// *** rtl/undervolt_pkg.sv ***
// Types for the low-voltage detect and reset controller.
package undervolt_pkg;
    typedef enum logic [1:0] {
        RST_LVL_4V1 = 2'b00,
        RST_LVL_3V7 = 2'b01,
        RST_LVL_2V4 = 2'b10,
        RST_POR_ONLY = 2'b11
    } reset_level_t;
    typedef enum logic [1:0] {
        DET_LVL_4V5 = 2'b00,
        DET_LVL_4V0 = 2'b01,
        DET_LVL_3V3 = 2'b10,
        DET_LVL_2V3 = 2'b11
    } detect_level_t;
    typedef enum logic [2:0] {
        DIP_IDLE = 3'b001,
        DIP_HOLD = 3'b010,
        DIP_RESET = 3'b100
    } dip_state_t;
endpackage : undervolt_pkg

// *** rtl/sync_bits.sv ***
// Two-flop synchroniser for a bundle of comparator levels.
`timescale 1ns/1ns
`default_nettype none
module sync_bits #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    // Next values: the first stage feeds only the second.
    always_comb
    begin
        nxt_stage1 = async_in;
        nxt_stage2 = stage1_ff;
    end

    // Registers of both stages; reset reads as no low voltage.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end
        else
        begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign sync_out = stage2_ff;
endmodule : sync_bits
`default_nettype wire

// *** rtl/low_voltage_detect_reset.sv ***
// Low-voltage detector control register, wake and dip-length reset logic.
//
// Functional notes
// RULE_01 - Two-bit reset option: 11 power-on only, 10/01/00 raise reset level.
// RULE_02 - Control bit 6 is the interrupt flag, set on detect, cleared by sw/hw.
// RULE_03 - Bit 5 reads 0 at or below detect level, 1 otherwise or disabled.
// RULE_04 - Bits 1:0 pick detect level 2.3, 3.3, 4.0 or 4.5 volts.
// RULE_05 - Bit 4 enables the detector interrupt request.
// RULE_06 - Bit 3 lets a low-voltage event wake the device from sleep.
// RULE_07 - Bit 2 enables the detector; disabled means no detect, flag or wake.
// RULE_08 - Detector runs in sleep; a crossing sets the flag and wakes.
// RULE_09 - Any system reset clears the interrupt flag.
// RULE_10 - Flag rises when supply falls below level; interrupt then taken.
// RULE_11 - Dip below reset level under 80 us holds state and halts core.
// RULE_12 - Dip below reset level over 80 us forces a full system reset.
// RULE_13 - Software sets level, wake, interrupt, enable, then sleeps and clears flag.
// RULE_14 - Comparator outputs are synchronised; flag sticks until cleared.
// RULE_15 - Dip length is counted in clock cycles against the 80 us limit.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "undervolt_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module low_voltage_detect_reset #(
    parameter int DIP_CYCLES = `UV_DIP_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire undervolt_pkg::reset_level_t reset_level_opt,
    input wire logic [3:0] detect_below,
    input wire logic [2:0] reset_below,
    input wire logic sleeping,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic undervolt_irq,
    output logic wake_req,
    output logic core_halt,
    output logic sys_reset_req,
    output logic irq
);
    import undervolt_pkg::*;

    localparam logic [7:0] CTRL_RESET = `UV_CTRL_RESET;
    localparam logic [7:0] CTRL_WMASK = `UV_CTRL_WMASK;
    localparam logic [15:0] DIP_LIMIT = 16'(DIP_CYCLES);

    logic [3:0] det_sync;
    logic [2:0] rst_sync;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [2:0] stat_ff;
    logic [2:0] nxt_stat;
    logic [2:0] mask_ff;
    logic [2:0] nxt_mask;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic low_prev_ff;
    logic nxt_low_prev;
    dip_state_t dip_ff;
    dip_state_t nxt_dip;
    logic [15:0] dip_cnt_ff;
    logic [15:0] nxt_dip_cnt;
    logic wake_ff;
    logic nxt_wake;
    logic det_en;
    logic supply_low;
    logic low_rise;
    logic below_reset;
    logic [2:0] events;

    // Selects the comparator that matches the chosen detect level.
    function automatic logic pick_detect(input logic [3:0] cmp, input detect_level_t lvl);
        case (lvl)
            DET_LVL_2V3: pick_detect = cmp[0];
            DET_LVL_3V3: pick_detect = cmp[1];
            DET_LVL_4V0: pick_detect = cmp[2];
            DET_LVL_4V5: pick_detect = cmp[3];
            default: pick_detect = 1'b0;
        endcase
    endfunction : pick_detect

    // Selects the reset comparator; power-on-only never trips here.
    function automatic logic pick_reset(input logic [2:0] cmp, input reset_level_t lvl);
        case (lvl)
            RST_LVL_2V4: pick_reset = cmp[0];
            RST_LVL_3V7: pick_reset = cmp[1];
            RST_LVL_4V1: pick_reset = cmp[2];
            RST_POR_ONLY: pick_reset = 1'b0;
            default: pick_reset = 1'b0;
        endcase
    endfunction : pick_reset

    // Comparator levels are brought into the clock domain first.
    sync_bits #(
        .WIDTH(7)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({reset_below, detect_below}),
        .sync_out({rst_sync, det_sync})
    ); // RULE_14

    // Detection terms derived from the control bits and comparators.
    always_comb
    begin
        det_en = ctrl_ff[`UV_BIT_EN]; // RULE_07
        supply_low = det_en && pick_detect(det_sync, detect_level_t'(ctrl_ff[1:0])); // RULE_04
        low_rise = supply_low && !low_prev_ff; // RULE_10
        below_reset = pick_reset(rst_sync, reset_level_opt); // RULE_01
        nxt_low_prev = supply_low;
    end

    // Control register: writable bits, state bit, sticky flag.
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (reg_wr && reg_addr == `UV_ADDR_CTRL)
        begin
            nxt_ctrl = (ctrl_ff & ~CTRL_WMASK) | (reg_wdata & CTRL_WMASK);
            if (!reg_wdata[`UV_BIT_FLAG])
            begin
                nxt_ctrl[`UV_BIT_FLAG] = 1'b0; // RULE_02
            end
        end
        nxt_ctrl[7] = 1'b0;
        nxt_ctrl[`UV_BIT_STATE] = !supply_low; // RULE_03
        if (low_rise)
        begin
            nxt_ctrl[`UV_BIT_FLAG] = 1'b1; // RULE_14
        end
    end

    // Interrupt status (write one to clear) and mask registers.
    always_comb
    begin
        events = 3'h0;
        events[`UV_EV_DETECT] = low_rise;
        events[`UV_EV_DIP] = (dip_ff == DIP_IDLE) && below_reset;
        events[`UV_EV_RESET] = (nxt_dip == DIP_RESET) && (dip_ff != DIP_RESET);
        nxt_stat = stat_ff;
        nxt_mask = mask_ff;
        if (reg_wr && reg_addr == `UV_ADDR_STAT)
        begin
            nxt_stat = stat_ff & ~reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == `UV_ADDR_MASK)
        begin
            nxt_mask = reg_wdata[2:0];
        end
        nxt_stat = nxt_stat | events;
    end

    // Dip timer: short dips halt with state kept, long ones reset.
    always_comb
    begin
        nxt_dip = dip_ff;
        nxt_dip_cnt = dip_cnt_ff;
        case (dip_ff)
            DIP_IDLE:
            begin
                nxt_dip_cnt = 16'h0000;
                if (below_reset)
                begin
                    nxt_dip = DIP_HOLD; // RULE_11
                    nxt_dip_cnt = 16'h0001;
                end
            end
            DIP_HOLD:
            begin
                if (!below_reset)
                begin
                    nxt_dip = DIP_IDLE;
                end
                else if (dip_cnt_ff >= DIP_LIMIT)
                begin
                    nxt_dip = DIP_RESET; // RULE_12
                end
                else
                begin
                    nxt_dip_cnt = dip_cnt_ff + 16'h0001; // RULE_15
                end
            end
            DIP_RESET:
            begin
                if (!below_reset)
                begin
                    nxt_dip = DIP_IDLE;
                end
            end
            default:
            begin
                nxt_dip = DIP_IDLE;
            end
        endcase
    end

    // Wake request and read data.
    always_comb
    begin
        nxt_wake = sleeping && low_rise && ctrl_ff[`UV_BIT_WE]; // RULE_06
        nxt_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `UV_ADDR_CTRL: nxt_rdata = ctrl_ff;
                `UV_ADDR_MASK: nxt_rdata = {5'h00, mask_ff};
                `UV_ADDR_STAT: nxt_rdata = {5'h00, stat_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // All state registers; reset clears the flag.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= CTRL_RESET; // RULE_09
            stat_ff <= 3'h0;
            mask_ff <= 3'h0;
            rdata_ff <= 8'h00;
            low_prev_ff <= 1'b0;
            dip_ff <= DIP_IDLE;
            dip_cnt_ff <= 16'h0000;
            wake_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            low_prev_ff <= nxt_low_prev;
            dip_ff <= nxt_dip;
            dip_cnt_ff <= nxt_dip_cnt;
            wake_ff <= nxt_wake;
        end
    end

    // Outputs; the core request needs the interrupt enable.
    assign reg_rdata = rdata_ff;
    assign undervolt_irq = ctrl_ff[`UV_BIT_FLAG] && ctrl_ff[`UV_BIT_IE]; // RULE_05
    assign wake_req = wake_ff; // RULE_08
    assign core_halt = (dip_ff == DIP_HOLD);
    assign sys_reset_req = (dip_ff == DIP_RESET);
    assign irq = |(stat_ff & mask_ff);
endmodule : low_voltage_detect_reset
`default_nettype wire

// *** tb/supply_model.sv ***
// Behavioural supply comparators standing in for the analog front end.
`timescale 1ns/1ns
`default_nettype none
module supply_model (
    input wire logic [15:0] supply_mv,
    output logic [3:0] detect_below,
    output logic [2:0] reset_below
);
    // Detectors trip at or below 2.3/3.3/4.0/4.5 V, reset comparators below 2.4/3.7/4.1 V.
    assign detect_below = {supply_mv <= 16'h1194, supply_mv <= 16'h0fa0,
        supply_mv <= 16'h0ce4, supply_mv <= 16'h08fc};
    assign reset_below = {supply_mv < 16'h1004, supply_mv < 16'h0e74, supply_mv < 16'h0960};
endmodule : supply_model
`default_nettype wire

// *** tb/low_voltage_detect_reset_props.sv ***
// Port-level assertions for the low-voltage detect and reset controller.
`timescale 1ns/1ns
`default_nettype none
module low_voltage_detect_reset_props #(
    parameter int DIP_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire undervolt_pkg::reset_level_t reset_level_opt,
    input wire logic [3:0] detect_below,
    input wire logic [2:0] reset_below,
    input wire logic sleeping,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic undervolt_irq,
    input wire logic wake_req,
    input wire logic core_halt,
    input wire logic sys_reset_req,
    input wire logic irq
);
    import undervolt_pkg::*;
    logic low;
    int cnt_ff;
    int nxt_cnt;
    // Raw comparator of the armed reset level; power-on only arms none.
    assign low = (reset_level_opt != RST_POR_ONLY) && reset_below[2'd2 - reset_level_opt];
    // Counts the length of the current dip in cycles.
    always_comb
    begin
        nxt_cnt = low ? cnt_ff + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n) cnt_ff <= 0;
        else cnt_ff <= nxt_cnt;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_dip; low [*4]; endsequence
    sequence s_ok; !low [*4]; endsequence
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_halt; s_dip |-> core_halt || sys_reset_req; endproperty
    a_halt: assert property (p_halt) else $error("dip not halted");
    property p_release; s_ok |-> !core_halt && !sys_reset_req; endproperty
    a_release: assert property (p_release) else $error("halt held");
    property p_por; (reset_level_opt == RST_POR_ONLY) [*4] |-> !core_halt && !sys_reset_req;
    endproperty
    a_por: assert property (p_por) else $error("reset level armed");
    property p_rst_early; $rose(sys_reset_req) |-> cnt_ff >= DIP_CYCLES; endproperty
    a_rst_early: assert property (p_rst_early) else $error("early reset");
    property p_rst_late; cnt_ff == DIP_CYCLES + 8 |-> sys_reset_req; endproperty
    a_rst_late: assert property (p_rst_late) else $error("late reset");
    property p_wake_pulse; wake_req |=> !wake_req; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
    property p_ie_off; reg_wr && reg_addr == 4'h0 && !reg_wdata[4] |-> ##[1:2] !undervolt_irq;
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("irq not masked");
endmodule : low_voltage_detect_reset_props
bind low_voltage_detect_reset low_voltage_detect_reset_props
    #(.DIP_CYCLES(DIP_CYCLES)) i_props (.*);
`default_nettype wire

// *** tb/low_voltage_detect_reset_bench.sv ***
// Register-level bench for the low-voltage detect and reset controller.
`timescale 1ns/1ns
`default_nettype none
module low_voltage_detect_reset_bench;
    import undervolt_pkg::*;
    reset_level_t reset_level_opt = RST_POR_ONLY;
    logic core_clk = 1'b0, reset_n = 1'b0, sleeping = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] supply_mv = 16'h1388;
    logic [3:0] detect_below, reg_addr = 4'h0;
    logic [2:0] reset_below;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic undervolt_irq, wake_req, core_halt, sys_reset_req, irq, saw_halt = 1'b0, saw_rst = 1'b0;
    int n_mismatch = 0, checks = 0, cyc = 0, n_wake = 0;
    logic [15:0] det_mv [4] = '{16'h1194, 16'h0fa0, 16'h0ce4, 16'h08fc};
    logic [15:0] rst_mv [3] = '{16'h1004, 16'h0e74, 16'h0960};
    supply_model i_supply (.*);
    low_voltage_detect_reset #(.DIP_CYCLES(20)) i_dut (.*);
    // Free-running core clock.
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    // Records wake pulses and dip responses; a hang counts as a mismatch.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        n_wake <= n_wake + int'(wake_req === 1'b1);
        saw_halt <= saw_halt | (core_halt === 1'b1);
        saw_rst <= saw_rst | (sys_reset_req === 1'b1);
        if (cyc == 4000)
        begin
            n_mismatch++;
            close_out;
        end
    end
    // Comparison, register access and supply tasks.
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(s, e, reg_rdata);
    endtask : rd
    task automatic vdd(input logic [15:0] mv);
        @(posedge core_clk);
        supply_mv <= mv;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
    endtask : vdd
    task automatic close_out;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // Levels, enable, interrupt and wake, then dips and a second reset.
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(4'h0, 8'h20, "ctrl reset");
        rd(4'hf, 8'h00, "unmapped");
        for (int c = 0; c < 4; c++)
        begin
            wr(4'h0, 8'h04 | 8'(c));
            vdd(det_mv[c] + 16'h0001);
            rd(4'h0, 8'h24 | 8'(c), "above");
            vdd(det_mv[c]);
            rd(4'h0, 8'h44 | 8'(c), "at level");
            vdd(16'h1388);
            rd(4'h0, 8'h64 | 8'(c), "sticky");
        end
        wr(4'h0, 8'h13);
        vdd(16'h07d0);
        rd(4'h0, 8'h33, "disabled");
        vdd(16'h1388);
        $display("levels done");
        wr(4'h2, 8'h07);
        wr(4'h1, 8'h01);
        sleeping <= 1'b1;
        wr(4'h0, 8'h1c);
        vdd(16'h1130);
        chk("uv irq", 8'h01, {7'h00, undervolt_irq});
        chk("irq", 8'h01, {7'h00, irq});
        chk("wake", 8'h01, n_wake[7:0]);
        wr(4'h1, 8'h00);
        rd(4'h2, 8'h01, "status");
        chk("masked", 8'h00, {7'h00, irq});
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00, "w1c");
        wr(4'h0, 8'h0c);
        vdd(16'h1388);
        vdd(16'h1130);
        chk("uv irq off", 8'h00, {7'h00, undervolt_irq});
        chk("wake on", 8'h02, n_wake[7:0]);
        wr(4'h0, 8'h04);
        vdd(16'h1388);
        vdd(16'h1130);
        chk("wake off", 8'h02, n_wake[7:0]);
        sleeping <= 1'b0;
        $display("irq done");
        wr(4'h0, 8'h00);
        for (int o = 0; o < 3; o++)
        begin
            @(posedge core_clk);
            reset_level_opt <= reset_level_t'(o);
            // Cleared off the rising edge so the recorder's update cannot undo it.
            @(negedge core_clk);
            saw_halt = 1'b0;
            vdd(rst_mv[o] - 16'h0001);
            vdd(16'h1388);
            chk("halt", 8'h01, {7'h00, saw_halt});
        end
        chk("short dip", 8'h00, {7'h00, saw_rst});
        rd(4'h0, 8'h20, "kept");
        wr(4'h0, 8'h04);
        vdd(16'h095f);
        repeat (30) @(posedge core_clk);
        vdd(16'h1388);
        chk("long dip", 8'h01, {7'h00, saw_rst});
        rd(4'h0, 8'h64, "flag set");
        rd(4'h2, 8'h07, "dip status");
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(4'h0, 8'h20, "flag reset");
        $display("dips done");
        close_out;
    end
endmodule : low_voltage_detect_reset_bench
`default_nettype wire
